// file: src/status_two_pkg.sv
// Constants and carrier types for the second flash status register
package status_two_pkg;

	// Command opcodes seen by the status block
	localparam logic [7:0] OP_SUSPEND    = 8'h75;
	localparam logic [7:0] OP_RESUME     = 8'h7A;
	localparam logic [7:0] OP_RST_ENABLE = 8'h66;
	localparam logic [7:0] OP_RST_DEVICE = 8'h99;

	// Field positions inside the register
	localparam int SUSPEND_BIT    = 7;
	localparam int COMPLEMENT_BIT = 6;
	localparam int LOCK_LSB       = 3;
	localparam int LOCK_COUNT     = 3;

	// Values after reset
	localparam logic       SUSPEND_RESET    = 1'b0;
	localparam logic       COMPLEMENT_RESET = 1'b0;
	localparam logic [2:0] LOCK_RESET       = 3'h0;

	// Security register geometry, last byte is the lock trigger
	localparam logic [6:0] SEC_LAST_BYTE = 7'h7F;
	localparam logic [1:0] SEC_FACTORY   = 2'h0;

	// APB byte addresses
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h00;
	localparam logic [7:0] ADDR_REFUSALS   = 8'h04;
	localparam logic [7:0] ADDR_COMMAND    = 8'h08;

	// Executed command from the serial command decoder
	typedef struct packed {
		logic       valid;
		logic [7:0] opcode;
	} cmd_t;

	// Byte program aimed at a security register
	typedef struct packed {
		logic       valid;
		logic [1:0] reg_sel;
		logic [6:0] byte_addr;
	} sec_prog_t;

	// Status register write command from the serial interface
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} status_wr_t;

endpackage

// file: src/otp_lock_cell.sv
// One-time lock bit: set by hardware, cleared only by reset
`timescale 1ns/1ns
module otp_lock_cell #(
	parameter logic RESET_VALUE = 1'b0
) (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic set_req,
	output logic      locked
);

	logic next_locked;

	// Sticky: once set nothing but reset returns it
	always_comb begin
		next_locked = locked | set_req;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			locked <= RESET_VALUE;
		end else begin
			locked <= next_locked;
		end
	end

endmodule // otp_lock_cell

// file: src/flash_status_reg_two.sv
// Second flash status register: suspend flag, complement bit, OTP locks
`timescale 1ns/1ns
module flash_status_reg_two #(
	parameter int REFUSE_WIDTH = 8
) (
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Flash core side
	input  wire status_two_pkg::cmd_t      cmd,
	input  wire status_two_pkg::status_wr_t status_wr,
	input  wire status_two_pkg::sec_prog_t sec_prog,
	input  wire logic                      hw_reset_req,
	input  wire logic                      bus_reset_req,
	output logic                           sec_prog_allow,
	output logic                           soft_reset_pulse,
	output logic                           protect_complement,
	output logic [7:0]                     status_two
);

	// Register state
	logic                    suspend_flag;
	logic                    next_suspend_flag;
	logic                    next_protect_complement;
	logic                    reset_armed;
	logic                    next_reset_armed;
	logic                    next_soft_reset_pulse;
	logic [REFUSE_WIDTH-1:0] refusals;
	logic [REFUSE_WIDTH-1:0] next_refusals;
	logic [31:0]             next_prdata;
	logic [2:0]              security_lock_bits;
	logic [2:0]              lock_set;

	// APB decode
	logic apb_setup;
	logic apb_write;
	logic addr_hit;
	logic bus_cmd_valid;
	logic bus_stat_wr;

	// Command seen either from the serial decoder or from software
	logic       any_cmd;
	logic [7:0] any_opcode;

	// Zero wait states keep the master simple
	assign pready    = 1'b1;
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;
	assign addr_hit  = (paddr == status_two_pkg::ADDR_STATUS_TWO) |
	                   (paddr == status_two_pkg::ADDR_REFUSALS) |
	                   (paddr == status_two_pkg::ADDR_COMMAND);
	assign pslverr   = psel & penable & ~addr_hit;

	// Software may inject a command byte or a status write
	assign bus_cmd_valid = apb_write & (paddr == status_two_pkg::ADDR_COMMAND);
	assign bus_stat_wr   = apb_write & (paddr == status_two_pkg::ADDR_STATUS_TWO);
	assign any_cmd       = cmd.valid | bus_cmd_valid;
	assign any_opcode    = cmd.valid ? cmd.opcode : pwdata[7:0];

	// Reset pair: 66h arms, 99h directly after fires
	always_comb begin
		next_reset_armed      = reset_armed;
		next_soft_reset_pulse = 1'b0;
		if (any_cmd) begin
			next_reset_armed = (any_opcode == status_two_pkg::OP_RST_ENABLE);
			next_soft_reset_pulse = reset_armed &
			                        (any_opcode == status_two_pkg::OP_RST_DEVICE);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			reset_armed      <= 1'b0;
			soft_reset_pulse <= 1'b0;
		end else begin
			reset_armed      <= next_reset_armed;
			soft_reset_pulse <= next_soft_reset_pulse;
		end
	end

	// Suspend flag; a suspend in the same cycle as a clear wins
	always_comb begin
		next_suspend_flag = suspend_flag;
		if ((any_cmd && any_opcode == status_two_pkg::OP_RESUME) ||
		    hw_reset_req || bus_reset_req || next_soft_reset_pulse) begin
			next_suspend_flag = 1'b0;
		end
		if (any_cmd && any_opcode == status_two_pkg::OP_SUSPEND) begin
			next_suspend_flag = 1'b1;
		end
	end

	// Complement bit, written by either status write path
	always_comb begin
		next_protect_complement = protect_complement;
		if (status_wr.valid) begin
			next_protect_complement = status_wr.data[status_two_pkg::COMPLEMENT_BIT];
		end else if (bus_stat_wr) begin
			next_protect_complement = pwdata[status_two_pkg::COMPLEMENT_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			suspend_flag       <= status_two_pkg::SUSPEND_RESET;
			protect_complement <= status_two_pkg::COMPLEMENT_RESET;
		end else begin
			suspend_flag       <= next_suspend_flag;
			protect_complement <= next_protect_complement;
		end
	end

	always_comb begin
		sec_prog_allow = 1'b0;
		case (sec_prog.reg_sel)
			2'h1: sec_prog_allow = ~security_lock_bits[0];
			2'h2: sec_prog_allow = ~security_lock_bits[1];
			2'h3: sec_prog_allow = ~security_lock_bits[2];
			default: sec_prog_allow = 1'b0;
		endcase
	end

	// last byte programmed sets the lock
	always_comb begin
		lock_set = 3'h0;
		if (sec_prog.valid && sec_prog_allow &&
		    sec_prog.byte_addr == status_two_pkg::SEC_LAST_BYTE) begin
			lock_set[sec_prog.reg_sel - 2'h1] = 1'b1;
		end
	end

	// lock cells reset to unlocked, no write path
	genvar gi;
	generate
		for (gi = 0; gi < status_two_pkg::LOCK_COUNT; gi++) begin : g_lock
			otp_lock_cell #(
				.RESET_VALUE (status_two_pkg::LOCK_RESET[gi])
			) u_lock (
				.core_clk (core_clk),
				.srst     (srst),
				.set_req  (lock_set[gi]),
				.locked   (security_lock_bits[gi])
			);
		end
	endgenerate

	// Count refused security programs, saturating so it never wraps
	always_comb begin
		next_refusals = refusals;
		if (sec_prog.valid && !sec_prog_allow && refusals != '1) begin
			next_refusals = refusals + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			refusals <= '0;
		end else begin
			refusals <= next_refusals;
		end
	end

	// bit order of the lock field
	// status writes reach only the complement bit
	always_comb begin
		status_two = 8'h00;
		status_two[status_two_pkg::SUSPEND_BIT]    = suspend_flag;
		status_two[status_two_pkg::COMPLEMENT_BIT] = protect_complement;
		status_two[status_two_pkg::LOCK_LSB +: 3]  = security_lock_bits;
	end

	// Read data captured in setup so it stands through the access phase
	always_comb begin
		next_prdata = prdata;
		if (apb_setup && !pwrite) begin
			case (paddr)
				status_two_pkg::ADDR_STATUS_TWO: next_prdata = {24'h000000, status_two};
				status_two_pkg::ADDR_REFUSALS:
					next_prdata = 32'(refusals);
				default: next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= next_prdata;
		end
	end

	// Checks on the register behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_suspend_sets: assert property (
		cmd.valid && cmd.opcode == status_two_pkg::OP_SUSPEND |=> status_two[7])
		else $error("suspend flag not set after suspend command");

	a_resume_clears: assert property (
		cmd.valid && cmd.opcode == status_two_pkg::OP_RESUME && !bus_cmd_valid
		|=> !status_two[7])
		else $error("suspend flag not cleared by resume");

	a_reset_clears: assert property (
		(hw_reset_req || bus_reset_req) && !(any_cmd &&
		any_opcode == status_two_pkg::OP_SUSPEND) |=> !status_two[7])
		else $error("suspend flag survived a reset request");

	a_pair_resets: assert property (
		soft_reset_pulse |-> !status_two[7])
		else $error("soft reset left suspend flag set");

	// Pair seen on the serial path must fire the soft reset one edge later
	a_pair_fires: assert property (
		(cmd.valid && cmd.opcode == status_two_pkg::OP_RST_ENABLE) ##1
		(cmd.valid && cmd.opcode == status_two_pkg::OP_RST_DEVICE)
		|=> soft_reset_pulse && !status_two[7])
		else $error("reset pair did not fire the soft reset");

	a_complement_write: assert property (
		status_wr.valid |=> protect_complement == $past(status_wr.data[6]))
		else $error("complement bit did not follow status write");

	// Bus write reaches the complement bit when the serial write is idle
	a_complement_bus: assert property (
		psel && penable && pwrite && paddr == status_two_pkg::ADDR_STATUS_TWO &&
		!status_wr.valid
		|=> protect_complement == $past(pwdata[status_two_pkg::COMPLEMENT_BIT]))
		else $error("complement bit did not follow bus write");

	a_lock_map: assert property (
		sec_prog.valid && sec_prog_allow && sec_prog.reg_sel == 2'h3 &&
		sec_prog.byte_addr == 7'h7F |=> status_two[5])
		else $error("register three program did not set bit 5");

	a_lock_two_map: assert property (
		sec_prog.valid && sec_prog_allow && sec_prog.reg_sel == 2'h2 &&
		sec_prog.byte_addr == 7'h7F |=> status_two[4])
		else $error("register two program did not set bit 4");

	a_lock_one_map: assert property (
		sec_prog.valid && sec_prog_allow && sec_prog.reg_sel == 2'h1 &&
		sec_prog.byte_addr == 7'h7F |=> status_two[3])
		else $error("register one program did not set bit 3");

	a_lock_last_only: assert property (
		sec_prog.valid && sec_prog.byte_addr != 7'h7F && !bus_stat_wr
		|=> $stable(status_two[5:3]))
		else $error("lock bit set by a byte other than the last");

	a_locked_refuses: assert property (
		sec_prog.reg_sel == 2'h1 && status_two[3] |-> !sec_prog_allow)
		else $error("locked register one accepted a program");

	a_lock_two_refuses: assert property (
		sec_prog.reg_sel == 2'h2 && status_two[4] |-> !sec_prog_allow)
		else $error("locked register two accepted a program");

	a_lock_three_refuses: assert property (
		sec_prog.reg_sel == 2'h3 && status_two[5] |-> !sec_prog_allow)
		else $error("locked register three accepted a program");

	a_factory_locked: assert property (
		sec_prog.reg_sel == 2'h0 |-> !sec_prog_allow)
		else $error("factory register accepted a program");

	a_lock_sticky: assert property (
		status_two[4] |=> status_two[4])
		else $error("lock bit cleared without reset");

	a_status_wr_ignores: assert property (
		status_wr.valid && !cmd.valid && !sec_prog.valid && !bus_cmd_valid &&
		!hw_reset_req && !bus_reset_req && !soft_reset_pulse
		|=> status_two[7] == $past(status_two[7]) &&
		    status_two[5:3] == $past(status_two[5:3]))
		else $error("status write changed a read-only bit");

	c_suspend_resume: cover property (
		status_two[7] ##[1:20] !status_two[7]);
	c_lock_set: cover property ($rose(status_two[3]));
	c_refused: cover property (sec_prog.valid && !sec_prog_allow);
	c_soft_reset: cover property (soft_reset_pulse);
	c_complement_set: cover property ($rose(protect_complement));

endmodule // flash_status_reg_two

// file: verif/flash_host_model.sv
// Host-side driver of flash commands, status writes and OTP programs
`timescale 1ns/1ns
module flash_host_model (
	input  wire logic                  core_clk,
	output status_two_pkg::cmd_t       cmd,
	output status_two_pkg::status_wr_t status_wr,
	output status_two_pkg::sec_prog_t  sec_prog
);
	// Idle interface at time zero
	initial begin
		cmd = '0;
		status_wr = '0;
		sec_prog = '0;
	end
	// Single command pulse; stale opcode inverted so it never looks valid data
	task automatic send_cmd(input logic [7:0] op);
		@(posedge core_clk);
		cmd <= '{valid: 1'h1, opcode: op};
		@(posedge core_clk);
		cmd <= '{valid: 1'h0, opcode: ~op};
	endtask
	// Two commands on consecutive edges, as a reset pair needs
	task automatic send_two(input logic [7:0] op_a, input logic [7:0] op_b);
		@(posedge core_clk);
		cmd <= '{valid: 1'h1, opcode: op_a};
		@(posedge core_clk);
		cmd <= '{valid: 1'h1, opcode: op_b};
		@(posedge core_clk);
		cmd <= '{valid: 1'h0, opcode: ~op_b};
	endtask
	// Status register write command
	task automatic write_status(input logic [7:0] data);
		@(posedge core_clk);
		status_wr <= '{valid: 1'h1, data: data};
		@(posedge core_clk);
		status_wr <= '{valid: 1'h0, data: ~data};
	endtask
	// Register select with no program, to probe the allow output
	task automatic hold_sel(input logic [1:0] sel);
		@(posedge core_clk);
		sec_prog <= '{valid: 1'h0, reg_sel: sel, byte_addr: 7'h00};
	endtask
	// One byte program into a security register
	task automatic program_sec(input logic [1:0] sel, input logic [6:0] addr);
		@(posedge core_clk);
		sec_prog <= '{valid: 1'h1, reg_sel: sel, byte_addr: addr};
		@(posedge core_clk);
		sec_prog <= '{valid: 1'h0, reg_sel: ~sel, byte_addr: ~addr};
	endtask
endmodule // flash_host_model

// file: verif/tb_flash_status_reg_two.sv
// Self-checking bench for the second flash status register
`timescale 1ns/1ns
module tb_flash_status_reg_two;
	logic                       core_clk, srst, psel, penable, pwrite;
	logic [7:0]                 paddr, status_two;
	logic [31:0]                pwdata, prdata, rd;
	logic                       pready, pslverr, err_seen, hw_reset_req, bus_reset_req;
	logic                       sec_prog_allow, soft_reset_pulse, protect_complement;
	status_two_pkg::cmd_t       cmd;
	status_two_pkg::status_wr_t status_wr;
	status_two_pkg::sec_prog_t  sec_prog;
	int                         num_errors, n_checks, cycles;
	// Opcode beside the suspend flag it should leave
	localparam logic [8:0] ROWS [9] = '{{8'h75, 1'h1}, {8'h7A, 1'h0}, {8'h75, 1'h1},
		{8'h99, 1'h1}, {8'h66, 1'h1}, {8'h75, 1'h1}, {8'h99, 1'h1}, {8'h7A, 1'h0},
		{8'h7A, 1'h0}};

	flash_status_reg_two #(.REFUSE_WIDTH(8)) flash_status_reg_two_i (.core_clk(core_clk),
		.srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd),
		.status_wr(status_wr), .sec_prog(sec_prog), .hw_reset_req(hw_reset_req),
		.bus_reset_req(bus_reset_req), .sec_prog_allow(sec_prog_allow),
		.soft_reset_pulse(soft_reset_pulse), .protect_complement(protect_complement),
		.status_two(status_two));
	flash_host_model flash_host_model_i (.core_clk(core_clk), .cmd(cmd),
		.status_wr(status_wr), .sec_prog(sec_prog));

	// 100 ns clock
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	// Hang guard, well above the hundred or so cycles the run needs
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Whole register compared once the launching edge has settled
	task automatic chk_st(input string what, input logic [7:0] exp);
		@(negedge core_clk);
		check(what, {24'h0, status_two}, {24'h0, exp});
	endtask
	// APB transfer; holds the request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rst_pulse(input logic hw);
		@(posedge core_clk);
		hw_reset_req <= hw;
		bus_reset_req <= ~hw;
		@(posedge core_clk);
		hw_reset_req <= 1'h0;
		bus_reset_req <= 1'h0;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{hw_reset_req, bus_reset_req, num_errors, n_checks, cycles} = '0;
		srst = 1'h1;
		repeat (20) @(posedge core_clk);
		srst <= 1'h0;
		chk_st("reset value", 8'h00);
		check("ready idle", {31'h0, pready}, 32'h1);
		apb(1'h0, status_two_pkg::ADDR_STATUS_TWO, 32'h0);
		check("reset read", rd, 32'h0);
		foreach (ROWS[i]) begin
			flash_host_model_i.send_cmd(ROWS[i][8:1]);
			chk_st("suspend row", {ROWS[i][0], 7'h0});
		end
		$display("test command table done");
		flash_host_model_i.send_cmd(8'h75);
		flash_host_model_i.send_two(8'h66, 8'h99);
		chk_st("soft reset clear", 8'h00);
		check("soft reset pulse", {31'h0, soft_reset_pulse}, 32'h1);
		apb(1'h1, status_two_pkg::ADDR_COMMAND, 32'h75);
		chk_st("apb suspend", 8'h80);
		rst_pulse(1'h1);
		chk_st("hw reset clear", 8'h00);
		apb(1'h1, status_two_pkg::ADDR_COMMAND, 32'h75);
		rst_pulse(1'h0);
		chk_st("bus reset clear", 8'h00);
		$display("test suspend clears done");
		apb(1'h1, status_two_pkg::ADDR_STATUS_TWO, 32'hFF);
		chk_st("complement set", 8'h40);
		check("complement out", {31'h0, protect_complement}, 32'h1);
		apb(1'h0, status_two_pkg::ADDR_STATUS_TWO, 32'h0);
		check("complement read", rd, 32'h40);
		flash_host_model_i.write_status(8'hBF);
		chk_st("complement clear", 8'h00);
		$display("test complement done");
		flash_host_model_i.send_cmd(8'h75);
		flash_host_model_i.hold_sel(2'h2);
		@(negedge core_clk);
		check("allow open", {31'h0, sec_prog_allow}, 32'h1);
		for (int i = 1; i < 4; i++) begin
			flash_host_model_i.program_sec(2'(i), 7'h7E);
			chk_st("lock early", 8'h80 | (((8'h1 << (i - 1)) - 8'h1) << 3));
			flash_host_model_i.program_sec(2'(i), status_two_pkg::SEC_LAST_BYTE);
			chk_st("lock set", 8'h80 | (((8'h1 << i) - 8'h1) << 3));
		end
		flash_host_model_i.hold_sel(2'h2);
		@(negedge core_clk);
		check("allow locked", {31'h0, sec_prog_allow}, 32'h0);
		apb(1'h1, status_two_pkg::ADDR_STATUS_TWO, 32'h0);
		chk_st("write ignored", 8'hB8);
		flash_host_model_i.program_sec(2'h0, 7'h10);
		flash_host_model_i.program_sec(2'h1, 7'h00);
		apb(1'h0, status_two_pkg::ADDR_REFUSALS, 32'h0);
		check("refusals", rd, 32'h2);
		$display("test security locks done");
		apb(1'h0, 8'h0C, 32'h0);
		check("unmapped data", rd, 32'h0);
		check("unmapped error", {31'h0, err_seen}, 32'h1);
		@(posedge core_clk);
		srst <= 1'h1;
		@(posedge core_clk);
		srst <= 1'h0;
		chk_st("second reset", 8'h00);
		$display("test unmapped and reset done");
		finish_test();
	end
endmodule // tb_flash_status_reg_two
